// File: bench/iprp_host_model.sv
`timescale 1ns/1ps
module iprp_host_model (
    // Clock
    input wire logic clk_i,
    // Bus lines, pull high when released
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    int quarter = 8;

    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Serves as first and repeated start
    task automatic start_cond();
        sda_pull_o = 1'b0;
        pause(quarter);
        scl_o = 1'b1;
        pause(quarter);
        sda_pull_o = 1'b1;
        pause(quarter);
        scl_o = 1'b0;
        pause(quarter);
    endtask

    task automatic stop_cond();
        sda_pull_o = 1'b1;
        pause(quarter);
        scl_o = 1'b1;
        pause(quarter);
        sda_pull_o = 1'b0;
        pause(quarter);
    endtask

    // Data moves only while the clock is low
    task automatic bit_out(input logic b);
        sda_pull_o = ~b;
        pause(quarter);
        scl_o = 1'b1;
        pause(2 * quarter);
        scl_o = 1'b0;
        pause(quarter);
    endtask

    task automatic bit_in(output logic b);
        sda_pull_o = 1'b0;
        pause(quarter);
        scl_o = 1'b1;
        pause(quarter);
        b = sda_i;
        pause(quarter);
        scl_o = 1'b0;
        pause(quarter);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(last);
    endtask
endmodule // iprp_host_model

// File: bench/iprp_top_tb.sv
`timescale 1ns/1ps
module iprp_top_tb;
    logic clk;
    logic srst;
    logic scl;
    logic sda_line;
    logic sda_drv;
    logic sda_oe;
    logic host_pull;
    logic [1:0] strap_level;
    logic ad_touch;
    logic [6:0] dot_idx;
    logic [7:0] dot_duty;
    logic [7:0] dot_scale;
    logic [7:0] page;
    logic [7:0] unlock_key;
    wire logic [7:0] fregs [7];
    logic save_pulse;
    logic touch_sel;
    int miscompares = 0;
    int num_checks = 0;
    int save_cycles = 0;
    localparam logic [7:0] FOFF [7] = '{8'h50, 8'h51, 8'h52, 8'h5f, 8'h60, 8'he0, 8'he2};

    assign sda_line = ~((sda_oe & ~sda_drv) | host_pull);

    iprp_top iprp_top_inst (
        .clk_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv), .sda_oe_o(sda_oe),
        .strap_level_i(strap_level), .ad_touch_i(ad_touch), .dot_idx_i(dot_idx), .dot_duty_o(dot_duty),
        .dot_scale_o(dot_scale), .page_o(page), .page_unlock_key_o(unlock_key),
        .operating_config_o(fregs[0]), .global_current_level_o(fregs[1]), .pull_resistor_select_o(fregs[2]),
        .thermal_point_o(fregs[3]), .spread_spectrum_ctrl_o(fregs[4]), .dimming_freq_enable_o(fregs[5]),
        .dimming_freq_setting_o(fregs[6]), .save_defaults_o(save_pulse), .touch_sel_o(touch_sel)
    );

    iprp_host_model host_inst (.clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(host_pull));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (save_pulse === 1'b1) save_cycles <= save_cycles + 1;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    function automatic logic [7:0] dev_addr(input logic [1:0] bits, input logic rd);
        return {iprp_pkg::SLAVE_ID_HI, bits, rd};
    endfunction

    // Negative count sends the header alone
    task automatic wr(input logic [7:0] hdr, input logic [7:0] ra, input logic [7:0] d0, input logic [7:0] d1,
                      input int n);
        logic ack;
        host_inst.start_cond();
        host_inst.send_byte(dev_addr(2'h3, 1'b0), ack);
        chk(ack, "addr nak");
        host_inst.send_byte(hdr, ack);
        chk(ack, "hdr nak");
        if (n >= 0) begin
            host_inst.send_byte(ra, ack);
            chk(ack, "reg nak");
        end
        for (int i = 0; i < n; i++) begin
            host_inst.send_byte(i == 0 ? d0 : d1, ack);
            chk(ack, "data nak");
        end
        host_inst.stop_cond();
        chk(sda_oe === 1'b0, "sda held");
    endtask

    task automatic set_page(input logic [7:0] p);
        wr(8'h55, iprp_pkg::REG_UNLOCK, iprp_pkg::UNLOCK_KEY, 8'h00, 1);
        wr(8'h55, iprp_pkg::REG_PAGE, p, 8'h00, 1);
    endtask

    task automatic dot_chk(input logic [6:0] idx, input logic [7:0] duty, input logic [7:0] scale);
        dot_idx = idx;
        repeat (2) @(negedge clk);
        chk(dot_duty === duty && dot_scale === scale, "dot value");
    endtask

    task automatic probe(input logic [1:0] bits, input logic exp);
        logic ack;
        host_inst.start_cond();
        host_inst.send_byte(dev_addr(bits, 1'b0), ack);
        host_inst.stop_cond();
        chk(ack === exp, "addr ack");
    endtask

    task automatic t_reset();
        chk(page === 8'h00 && unlock_key === 8'h00 && sda_oe === 1'b0, "reset page");
        for (int i = 0; i < 7; i++) begin
            chk(fregs[i] === (i == 2 ? 8'h33 : 8'h00), "reset func");
        end
        dot_chk(7'h00, 8'h00, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_strap();
        for (int s = 0; s < 4; s++) begin
            strap_level = 2'(s);
            repeat (8) @(negedge clk);
            probe(2'(s), 1'b1);
            probe(2'(s) ^ 2'h1, 1'b0);
        end
        ad_touch = 1'b1;
        repeat (8) @(negedge clk);
        probe(2'h0, 1'b1);
        probe(2'h3, 1'b0);
        ad_touch = 1'b0;
        repeat (8) @(negedge clk);
        $display("test strap done");
    endtask

    task automatic t_page_lock();
        wr(8'h55, iprp_pkg::REG_PAGE, 8'h01, 8'h00, 1);
        chk(page === 8'h00, "locked page moved");
        wr(8'h55, iprp_pkg::REG_UNLOCK, 8'hc5, 8'h00, 1);
        chk(unlock_key === 8'hc5, "key");
        wr(8'h55, iprp_pkg::REG_PAGE, 8'h02, 8'h00, 1);
        chk(page === 8'h00 && unlock_key === 8'hc5, "reserved page");
        wr(8'h55, iprp_pkg::REG_PAGE, 8'h01, 8'h00, 1);
        chk(page === 8'h01 && unlock_key === 8'h00, "unlocked write");
        wr(8'h55, iprp_pkg::REG_PAGE, 8'h00, 8'h00, 1);
        chk(page === 8'h01, "second write");
        $display("test page_lock done");
    endtask

    task automatic t_arrays();
        wr(8'h55, 8'h01, 8'haa, 8'h00, 1);
        host_inst.quarter = 20;
        wr(8'h55, 8'h47, 8'h5b, 8'h6c, 2);
        host_inst.quarter = 8;
        set_page(8'h00);
        wr(8'h55, 8'h01, 8'h3c, 8'h00, 1);
        wr(8'h55, 8'h48, 8'hff, 8'h00, 1);
        wr(8'h55, 8'h51, 8'h99, 8'h00, 1);
        chk(fregs[1] === 8'h00, "func on page 0");
        dot_chk(7'd0, 8'h3c, 8'haa);
        dot_chk(7'd71, 8'hff, 8'h6c);
        dot_chk(7'd70, 8'h00, 8'h5b);
        set_page(8'h01);
        $display("test arrays done");
    endtask

    task automatic t_func();
        for (int i = 0; i < 7; i++) begin
            wr(8'h55, FOFF[i], FOFF[i] ^ 8'h5a, 8'h00, 1);
            chk(fregs[i] === (FOFF[i] ^ 8'h5a), "func write");
        end
        $display("test func done");
    endtask

    task automatic t_header();
        wr(8'ha5, 8'h00, 8'h00, 8'h00, -1);
        chk(save_cycles == 1, "save pulse");
        wr(8'haa, 8'h51, 8'h99, 8'h00, 1);
        chk(touch_sel === 1'b1 && fregs[1] === 8'h0b, "touch hdr");
        wr(8'h55, 8'h51, 8'h77, 8'h00, 1);
        chk(touch_sel === 1'b0 && fregs[1] === 8'h77, "led hdr");
        wr(8'h55, iprp_pkg::REG_SOFT_RST, 8'h00, 8'h00, 1);
        chk(page === 8'h00 && unlock_key === 8'h00 && fregs[1] === 8'h0b, "soft reset");
        dot_chk(7'd0, 8'h00, 8'h00);
        $display("test header done");
    endtask

    task automatic t_read();
        logic ack;
        logic [7:0] d0;
        logic [7:0] d1;
        wr(8'h55, iprp_pkg::REG_UNLOCK, 8'hc5, 8'h00, 1);
        host_inst.start_cond();
        host_inst.send_byte(dev_addr(2'h3, 1'b0), ack);
        host_inst.send_byte(8'h55, ack);
        host_inst.send_byte(iprp_pkg::REG_UNLOCK, ack);
        host_inst.start_cond();
        host_inst.send_byte(dev_addr(2'h3, 1'b1), ack);
        chk(ack, "read addr");
        host_inst.recv_byte(1'b0, d0);
        host_inst.recv_byte(1'b1, d1);
        host_inst.stop_cond();
        chk(d0 === 8'hc5 && d1 === 8'hc5 && sda_oe === 1'b0, "read data");
        $display("test read done");
    endtask

    initial begin
        srst = 1'b1;
        strap_level = 2'h3;
        ad_touch = 1'b0;
        dot_idx = 7'h00;
        repeat (6) @(negedge clk);
        srst = 1'b0;
        repeat (6) @(negedge clk);
        t_reset();
        t_strap();
        t_page_lock();
        t_arrays();
        t_func();
        t_header();
        t_read();
        complete_run();
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        $display("[FAIL] %0t hang", $time);
        complete_run();
    end
endmodule // iprp_top_tb

// File: verilog/iprp_line_events.sv
`timescale 1ns/1ps
module iprp_line_events (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Synchronised bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    // Events, one cycle each, plus the delayed data level on sda_o
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic start_o,
    output logic stop_o,
    output logic sda_o
);
    typedef struct packed {
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } iprp_ev_st_t;

    iprp_ev_st_t s_q;
    iprp_ev_st_t s_d;

    always_comb begin
        s_d.scl = scl_i;
        s_d.sda = sda_i;
        s_d.rise = scl_i & ~s_q.scl;
        s_d.fall = ~scl_i & s_q.scl;
        // Data edge while clock stays high
        s_d.start = scl_i & s_q.scl & s_q.sda & ~sda_i;
        s_d.stop = scl_i & s_q.scl & ~s_q.sda & sda_i;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign scl_rise_o = s_q.rise;
    assign scl_fall_o = s_q.fall;
    assign start_o = s_q.start;
    assign stop_o = s_q.stop;
    assign sda_o = s_q.sda;
endmodule // iprp_line_events

// File: verilog/iprp_pkg.sv
package iprp_pkg;
    // Slave address
    localparam logic [4:0] SLAVE_ID_HI = 5'h0f;
    localparam logic [1:0] STRAP_TOUCH = 2'h0;
    // Header codes
    localparam logic [7:0] HDR_LED = 8'h55;
    localparam logic [7:0] HDR_TOUCH = 8'haa;
    localparam logic [7:0] HDR_SAVE = 8'ha5;
    // Register offsets
    localparam logic [7:0] REG_PAGE = 8'hfd;
    localparam logic [7:0] REG_UNLOCK = 8'hfe;
    localparam logic [7:0] DOT_FIRST = 8'h01;
    localparam logic [7:0] DOT_LAST = 8'h48;
    localparam int DOT_COUNT = 72;
    localparam logic [7:0] REG_CFG = 8'h50;
    localparam logic [7:0] REG_GCC = 8'h51;
    localparam logic [7:0] REG_PULL = 8'h52;
    localparam logic [7:0] REG_THERM = 8'h5f;
    localparam logic [7:0] REG_SPREAD = 8'h60;
    localparam logic [7:0] REG_SOFT_RST = 8'h8f;
    localparam logic [7:0] REG_FREQ_EN = 8'he0;
    localparam logic [7:0] REG_FREQ_SET = 8'he2;
    // Values
    localparam logic [7:0] UNLOCK_KEY = 8'hc5;
    localparam logic [7:0] PAGE_DUTY = 8'h00;
    localparam logic [7:0] PAGE_SCALE = 8'h01;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_UNLOCK = 8'h00;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_HDR, ST_REG, ST_WDATA, ST_RDATA} iprp_state_t;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] global_current_level;
        logic [7:0] pull;
        logic [7:0] therm;
        logic [7:0] spread;
        logic [7:0] freq_en;
        logic [7:0] freq_set;
    } iprp_func_t;

    localparam iprp_func_t FUNC_RST = '{cfg: 8'h00, global_current_level: 8'h00, pull: 8'h33, therm: 8'h00,
        spread: 8'h00, freq_en: 8'h00, freq_set: 8'h00};
endpackage

// File: verilog/iprp_sync.sv
`timescale 1ns/1ps
module iprp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Asynchronous levels in, synchronous levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } iprp_sync_st_t;

    iprp_sync_st_t s_q;
    iprp_sync_st_t s_d;

    always_comb begin
        s_d.meta = d_i;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.sync;
endmodule // iprp_sync

// File: verilog/iprp_top.sv
// Functional notes
// - Answer only address 01111 plus strap bits
// - Address LSB selects write zero, read one
// - Strap level maps to address bits 00..11
// - Touch-key strap use forces bits to 00
// - START restarts address compare
// - Matching address acknowledged through whole pulse
// - Header byte received and acknowledged
// - Register address byte received and acknowledged
// - Each data byte received and acknowledged
// - STOP ends every transfer
// - Repeated START with read returns the unlock register, other registers read 00h
// - Header 55h to LED, AAh to touch
// - Header A5h saves registers as defaults
// - Page select 00 duty, 01 scale/function
// - Key C5h allows one page change
// - Page select powers up at page 0
// - Page 0 01h-48h hold dot duty bytes
// - Write to 8Fh on page 01 restores reset values, function registers from saved defaults
`timescale 1ns/1ps
module iprp_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Serial bus, open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Address strap
    input wire logic [1:0] strap_level_i,
    input wire logic ad_touch_i,
    // Dot readout for the matrix engine
    input wire logic [6:0] dot_idx_i,
    output logic [7:0] dot_duty_o,
    output logic [7:0] dot_scale_o,
    // Register contents
    output logic [7:0] page_o,
    output logic [7:0] page_unlock_key_o,
    output logic [7:0] operating_config_o,
    output logic [7:0] global_current_level_o,
    output logic [7:0] pull_resistor_select_o,
    output logic [7:0] thermal_point_o,
    output logic [7:0] spread_spectrum_ctrl_o,
    output logic [7:0] dimming_freq_enable_o,
    output logic [7:0] dimming_freq_setting_o,
    // Save-defaults pulse and touch header select level
    output logic save_defaults_o,
    output logic touch_sel_o
);
    typedef struct packed {
        iprp_pkg::iprp_state_t state;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] hdr;
        logic [7:0] addr;
        logic sda_oe;
        logic [7:0] page;
        logic [7:0] unlock;
        iprp_pkg::iprp_func_t func;
        iprp_pkg::iprp_func_t dflt;
        logic [iprp_pkg::DOT_COUNT-1:0][7:0] duty;
        logic [iprp_pkg::DOT_COUNT-1:0][7:0] scale;
        logic [7:0] dot_duty;
        logic [7:0] dot_scale;
        logic save;
        logic touch;
    } iprp_top_st_t;

    localparam iprp_top_st_t ST_RST = '{
        state: iprp_pkg::ST_IDLE,
        page: iprp_pkg::RST_PAGE,
        unlock: iprp_pkg::RST_UNLOCK,
        func: iprp_pkg::FUNC_RST,
        dflt: iprp_pkg::FUNC_RST,
        default: '0
    };

    function automatic logic is_dot(input logic [7:0] a);
        is_dot = (a >= iprp_pkg::DOT_FIRST) && (a <= iprp_pkg::DOT_LAST);
    endfunction

    iprp_top_st_t s_q;
    iprp_top_st_t s_d;
    logic [4:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [1:0] lvl_s;
    logic touch_s;
    logic ev_rise;
    logic ev_fall;
    logic ev_start;
    logic ev_stop;
    logic sda_ev;
    logic [1:0] strap_bits;
    logic addr_match;
    logic byte_done;
    logic wr_en;
    logic [7:0] rd_byte;
    logic [6:0] wr_idx;

    iprp_sync #(.W(5)) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i({scl_i, sda_i, strap_level_i, ad_touch_i}),
        .q_o(pins_s)
    );

    assign {scl_s, sda_s, lvl_s, touch_s} = pins_s;

    iprp_line_events u_ev (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .scl_i(scl_s),
        .sda_i(sda_s),
        .scl_rise_o(ev_rise),
        .scl_fall_o(ev_fall),
        .start_o(ev_start),
        .stop_o(ev_stop),
        .sda_o(sda_ev)
    );

    assign strap_bits = touch_s ? iprp_pkg::STRAP_TOUCH : lvl_s;
    assign addr_match = s_q.shreg[7:1] == {iprp_pkg::SLAVE_ID_HI, strap_bits};
    assign byte_done = ev_fall && (s_q.cnt == iprp_pkg::LAST_BIT) && (s_q.state != iprp_pkg::ST_IDLE);
    assign wr_en = byte_done && (s_q.state == iprp_pkg::ST_WDATA) && (s_q.hdr == iprp_pkg::HDR_LED);
    assign wr_idx = 7'(s_q.addr - iprp_pkg::DOT_FIRST);
    // Only the unlock register reads back; the rest are write-only
    assign rd_byte = (s_q.hdr == iprp_pkg::HDR_LED && s_q.addr == iprp_pkg::REG_UNLOCK) ? s_q.unlock : 8'h00;

    always_comb begin
        s_d = s_q;
        s_d.save = 1'b0;
        if (ev_start) begin
            s_d.state = iprp_pkg::ST_ADDR;
            // The clock fall that closes START wraps this to bit zero
            s_d.cnt = 4'hf;
            s_d.sda_oe = 1'b0;
        end else if (ev_stop) begin
            s_d.state = iprp_pkg::ST_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (s_q.state != iprp_pkg::ST_IDLE) begin
            if (ev_rise && s_q.cnt < iprp_pkg::ACK_SLOT && s_q.state != iprp_pkg::ST_RDATA) begin
                s_d.shreg = {s_q.shreg[6:0], sda_ev};
            end
            if (ev_rise && s_q.cnt == iprp_pkg::ACK_SLOT && s_q.state == iprp_pkg::ST_RDATA && sda_ev) begin
                s_d.state = iprp_pkg::ST_IDLE;
            end
            if (ev_fall) begin
                if (s_q.cnt == iprp_pkg::ACK_SLOT) begin
                    s_d.cnt = 4'h0;
                    s_d.sda_oe = 1'b0;
                    if (s_q.state == iprp_pkg::ST_RDATA) begin
                        s_d.shreg = rd_byte;
                        s_d.sda_oe = ~rd_byte[7];
                    end
                end else begin
                    s_d.cnt = s_q.cnt + 4'h1;
                    if (s_q.state == iprp_pkg::ST_RDATA) begin
                        s_d.shreg = {s_q.shreg[6:0], 1'b0};
                        s_d.sda_oe = ~s_q.shreg[6] && (s_q.cnt != iprp_pkg::LAST_BIT);
                    end
                end
            end
            if (byte_done) begin
                unique case (s_q.state)
                    iprp_pkg::ST_ADDR: begin
                        if (addr_match) begin
                            s_d.sda_oe = 1'b1;
                            s_d.state = s_q.shreg[0] ? iprp_pkg::ST_RDATA : iprp_pkg::ST_HDR;
                        end else begin
                            s_d.state = iprp_pkg::ST_IDLE;
                        end
                    end
                    iprp_pkg::ST_HDR: begin
                        s_d.sda_oe = 1'b1;
                        s_d.hdr = s_q.shreg;
                        s_d.touch = s_q.shreg == iprp_pkg::HDR_TOUCH;
                        if (s_q.shreg == iprp_pkg::HDR_SAVE) begin
                            s_d.save = 1'b1;
                            s_d.dflt = s_q.func;
                        end
                        s_d.state = iprp_pkg::ST_REG;
                    end
                    iprp_pkg::ST_REG: begin
                        s_d.sda_oe = 1'b1;
                        s_d.addr = s_q.shreg;
                        s_d.state = iprp_pkg::ST_WDATA;
                    end
                    iprp_pkg::ST_WDATA: begin
                        s_d.sda_oe = 1'b1;
                        s_d.addr = s_q.addr + 8'h01;
                    end
                    iprp_pkg::ST_RDATA: begin
                        s_d.sda_oe = 1'b0;
                    end
                    iprp_pkg::ST_IDLE: begin
                        s_d.sda_oe = 1'b0;
                    end
                endcase
            end
        end
        if (wr_en) begin
            if (s_q.addr == iprp_pkg::REG_PAGE) begin
                if (s_q.unlock == iprp_pkg::UNLOCK_KEY &&
                    (s_q.shreg == iprp_pkg::PAGE_DUTY || s_q.shreg == iprp_pkg::PAGE_SCALE)) begin
                    s_d.page = s_q.shreg;
                    s_d.unlock = iprp_pkg::RST_UNLOCK;
                end
            end else if (s_q.addr == iprp_pkg::REG_UNLOCK) begin
                s_d.unlock = s_q.shreg;
            end else if (is_dot(s_q.addr)) begin
                if (s_q.page == iprp_pkg::PAGE_DUTY) begin
                    s_d.duty[wr_idx] = s_q.shreg;
                end else begin
                    s_d.scale[wr_idx] = s_q.shreg;
                end
            end else if (s_q.page == iprp_pkg::PAGE_SCALE) begin
                unique case (s_q.addr)
                    iprp_pkg::REG_CFG: s_d.func.cfg = s_q.shreg;
                    iprp_pkg::REG_GCC: s_d.func.global_current_level = s_q.shreg;
                    iprp_pkg::REG_PULL: s_d.func.pull = s_q.shreg;
                    iprp_pkg::REG_THERM: s_d.func.therm = s_q.shreg;
                    iprp_pkg::REG_SPREAD: s_d.func.spread = s_q.shreg;
                    iprp_pkg::REG_FREQ_EN: s_d.func.freq_en = s_q.shreg;
                    iprp_pkg::REG_FREQ_SET: s_d.func.freq_set = s_q.shreg;
                    iprp_pkg::REG_SOFT_RST: begin
                        s_d.page = iprp_pkg::RST_PAGE;
                        s_d.unlock = iprp_pkg::RST_UNLOCK;
                        s_d.func = s_q.dflt;
                        s_d.duty = '0;
                        s_d.scale = '0;
                    end
                    default: begin
                    end
                endcase
            end
        end
        s_d.dot_duty = (dot_idx_i < 7'(iprp_pkg::DOT_COUNT)) ? s_q.duty[dot_idx_i] : 8'h00;
        s_d.dot_scale = (dot_idx_i < 7'(iprp_pkg::DOT_COUNT)) ? s_q.scale[dot_idx_i] : 8'h00;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = s_q.sda_oe;
    assign dot_duty_o = s_q.dot_duty;
    assign dot_scale_o = s_q.dot_scale;
    assign page_o = s_q.page;
    assign page_unlock_key_o = s_q.unlock;
    assign operating_config_o = s_q.func.cfg;
    assign global_current_level_o = s_q.func.global_current_level;
    assign pull_resistor_select_o = s_q.func.pull;
    assign thermal_point_o = s_q.func.therm;
    assign spread_spectrum_ctrl_o = s_q.func.spread;
    assign dimming_freq_enable_o = s_q.func.freq_en;
    assign dimming_freq_setting_o = s_q.func.freq_set;
    assign save_defaults_o = s_q.save;
    assign touch_sel_o = s_q.touch;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    logic [6:0] exp_id;
    assign exp_id = {5'h0f, ad_touch_i ? 2'b00 : strap_level_i};

    addr_ack_a: assert property (byte_done && s_q.state == iprp_pkg::ST_ADDR
        && s_q.shreg[7:1] == exp_id && $stable(exp_id) |=> sda_oe_o)
        else $error("matching address not acknowledged");
    foreign_nack_a: assert property (byte_done && s_q.state == iprp_pkg::ST_ADDR
        && s_q.shreg[7:1] != exp_id && $stable(exp_id) |=> !sda_oe_o && s_q.state == iprp_pkg::ST_IDLE)
        else $error("foreign address acknowledged");
    ack_hold_a: assert property (sda_oe_o && s_q.cnt == 4'h8 && !ev_fall && !ev_start && !ev_stop
        |=> sda_oe_o)
        else $error("acknowledge released early");
    hdr_ack_a: assert property (byte_done && s_q.state == iprp_pkg::ST_HDR
        |=> sda_oe_o && s_q.state == iprp_pkg::ST_REG && s_q.cnt == 4'h8)
        else $error("header not acknowledged");
    rw_dir_a: assert property (byte_done && s_q.state == iprp_pkg::ST_ADDR && addr_match
        |=> s_q.state == (($past(s_q.shreg[0])) ? iprp_pkg::ST_RDATA : iprp_pkg::ST_HDR))
        else $error("direction bit misread");
    start_a: assert property (ev_start |=> s_q.state == iprp_pkg::ST_ADDR && s_q.cnt == 4'hf)
        else $error("start not taken");
    stop_a: assert property (ev_stop && !ev_start |=> s_q.state == iprp_pkg::ST_IDLE && !sda_oe_o)
        else $error("stop not taken");
    save_a: assert property (byte_done && s_q.state == iprp_pkg::ST_HDR
        && s_q.shreg == 8'ha5 |=> save_defaults_o ##1 !save_defaults_o)
        else $error("save pulse missing");
    page_lock_a: assert property (wr_en && s_q.addr == 8'hfd && s_q.unlock != 8'hc5
        |=> $stable(page_o))
        else $error("locked page changed");
    unlock_once_a: assert property (wr_en && s_q.addr == 8'hfd && s_q.unlock == 8'hc5
        && s_q.shreg == 8'h01 |=> page_o == 8'h01 && page_unlock_key_o == 8'h00)
        else $error("unlock not consumed");
    soft_rst_a: assert property (wr_en && s_q.addr == 8'h8f && s_q.page == 8'h01
        |=> page_o == 8'h00 && s_q.duty == '0 ##1 dot_duty_o == 8'h00)
        else $error("soft reset incomplete");
    duty_page_a: assert property (wr_en && s_q.addr == 8'h01 && s_q.page == 8'h00
        |=> s_q.duty[0] == $past(s_q.shreg) && $stable(s_q.scale))
        else $error("page routing wrong");
    // Acknowledge, routing and page guards
    reg_ack_a: assert property (byte_done && s_q.state == iprp_pkg::ST_REG
        |=> sda_oe_o && s_q.state == iprp_pkg::ST_WDATA && s_q.addr == $past(s_q.shreg))
        else $error("register address not acknowledged");
    data_ack_a: assert property (byte_done && s_q.state == iprp_pkg::ST_WDATA
        |=> sda_oe_o && s_q.cnt == 4'h8)
        else $error("data byte not acknowledged");
    led_route_a: assert property (byte_done && s_q.state == iprp_pkg::ST_WDATA && s_q.hdr != 8'h55
        |=> $stable(page_o) && $stable(page_unlock_key_o) && $stable(global_current_level_o))
        else $error("non-LED header wrote a register");
    touch_sel_a: assert property (byte_done && s_q.state == iprp_pkg::ST_HDR
        |=> touch_sel_o == ($past(s_q.shreg) == 8'haa))
        else $error("touch routing wrong");
    rd_release_a: assert property (byte_done && s_q.state == iprp_pkg::ST_RDATA
        |=> !sda_oe_o)
        else $error("data line held in master acknowledge");
    func_page_a: assert property (wr_en && s_q.addr == 8'h51 && s_q.page == 8'h00
        |=> $stable(global_current_level_o))
        else $error("function register written on page 0");
    reserved_page_a: assert property (wr_en && s_q.addr == 8'hfd && s_q.shreg > 8'h01
        |=> $stable(page_o) && $stable(page_unlock_key_o))
        else $error("reserved page accepted");
    unlock_wr_a: assert property (wr_en && s_q.addr == 8'hfe
        |=> page_unlock_key_o == $past(s_q.shreg))
        else $error("unlock key not stored");

    read_c: cover property (byte_done && s_q.state == iprp_pkg::ST_RDATA);
    page_c: cover property (wr_en && s_q.addr == 8'hfd && s_q.unlock == 8'hc5);
    save_c: cover property (save_defaults_o);
    soft_rst_c: cover property (wr_en && s_q.addr == 8'h8f && s_q.page == 8'h01);
    touch_c: cover property (touch_sel_o);
endmodule // iprp_top
